// ===== sync_usart_pkg.sv
// package: register map, field positions and constants of the synchronous serial port
package sync_usart_pkg;
  // =====================================================================
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_RX_STATUS = 8'h18;
  localparam logic [7:0] IDX_TX_BUFFER = 8'h19;
  localparam logic [7:0] IDX_RX_BUFFER = 8'h1A;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_TX_STATUS = 8'h98;
  localparam logic [7:0] IDX_BAUD = 8'h99;
  localparam int ADDR_SHIFT = 2;
  // =====================================================================
  // field positions
  localparam int RCV_SERIAL_PORT_ENABLE = 7;
  localparam int RCV_NINE = 6;
  localparam int RCV_SINGLE = 5;
  localparam int RCV_CONT = 4;
  localparam int RCV_OVERRUN = 1;
  localparam int RCV_NINTH = 0;
  localparam int TXS_CLKSRC = 7;
  localparam int TXS_NINE = 6;
  localparam int TXS_ENABLE = 5;
  localparam int TXS_SYNC = 4;
  localparam int TXS_HIGHBAUD = 2;
  localparam int TXS_EMPTY = 1;
  localparam int TXS_NINTH = 0;
  localparam int IRQ_RX = 5;
  localparam int IRQ_TX = 4;
  // =====================================================================
  // reset values and counts
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  typedef enum logic [2:0]
  {
    IDLE = 3'b001,
    RECV = 3'b010,
    SEND = 3'b100
  } link_state_e;
endpackage

// ===== sync_usart_rx.sv
// module: synchronous serial port, receive path, two-deep fifo and slave operation
module sync_usart_rx
  import sync_usart_pkg::*;
#(
  parameter int DIV_WIDTH = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleeping,
  output logic irq_request,
  output logic wake_request,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe
);
  // =====================================================================
  // registers
  logic [7:0] irq_enables;
  logic [7:0] baud_divisor;
  logic serial_port_enable, nine_bit_receive_enable;
  logic single_receive_enable, continuous_receive_enable, overrun_error;
  logic clock_source_select, nine_bit_transmit_enable, transmit_enable;
  logic sync_mode, high_baud_select, transmit_ninth_bit;
  logic [7:0] transmit_buffer;
  logic tx_buffer_full;
  logic [8:0] fifo_mem [2];
  logic fifo_rd_ptr, fifo_wr_ptr;
  logic [1:0] fifo_count;
  logic [8:0] receive_shifter;
  logic [8:0] transmit_shifter;
  logic [3:0] bit_count;
  link_state_e state;
  logic [DIV_WIDTH-1:0] baud_count;
  logic clk_gen;
  logic clk_s1, clk_s2, clk_prev, dat_s1, dat_s2;

  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction

  // =====================================================================
  // bus decode
  logic wr_access, rd_access;
  logic mapped;
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign pready = 1'b1;
  always_comb
  begin
    mapped = 1'b1;
    if (hit(paddr, IDX_IRQ_FLAGS)) mapped = 1'b1;
    else if (hit(paddr, IDX_RX_STATUS)) mapped = 1'b1;
    else if (hit(paddr, IDX_TX_BUFFER)) mapped = 1'b1;
    else if (hit(paddr, IDX_RX_BUFFER)) mapped = 1'b1;
    else if (hit(paddr, IDX_IRQ_ENABLES)) mapped = 1'b1;
    else if (hit(paddr, IDX_TX_STATUS)) mapped = 1'b1;
    else if (hit(paddr, IDX_BAUD)) mapped = 1'b1;
    else mapped = 1'b0;
  end
  // unmapped addresses answer with an error and read zero
  assign pslverr = psel && penable && !mapped;

  logic wr_rx_status, wr_tx_buffer, rd_rx_buffer;
  assign wr_rx_status = wr_access && hit(paddr, IDX_RX_STATUS);
  assign wr_tx_buffer = wr_access && hit(paddr, IDX_TX_BUFFER);
  assign rd_rx_buffer = rd_access && hit(paddr, IDX_RX_BUFFER);

  // =====================================================================
  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_s1 <= 1'b1;
      clk_s2 <= 1'b1;
      clk_prev <= 1'b1;
      dat_s1 <= 1'b1;
      dat_s2 <= 1'b1;
    end
    else
    begin
      clk_s1 <= serial_clock_pin_in;
      clk_s2 <= clk_s1;
      clk_prev <= clk_s2;
      dat_s1 <= serial_data_pin_in;
      dat_s2 <= dat_s1;
    end
  end

  // =====================================================================
  // shift clock: internal divider in master mode, external pin in slave mode
  logic master, link_on, clk_line, rise, fall, want_rx, want_tx;
  logic [3:0] word_bits;
  assign master = clock_source_select;
  assign link_on = serial_port_enable && sync_mode;
  // slave ignores the single enable; continuous always wins over single
  assign want_rx = link_on && (continuous_receive_enable || (single_receive_enable && master));
  assign want_tx = link_on && transmit_enable;
  assign clk_line = master ? clk_gen : clk_s2;
  assign rise = master ? (baud_count == '0 && !clk_gen) : (clk_s2 && !clk_prev);
  assign fall = master ? (baud_count == '0 && clk_gen) : (!clk_s2 && clk_prev);
  assign word_bits = nine_bit_receive_enable ? BITS_NINE : BITS_EIGHT;

  // idles high, runs only in a transfer so its first fall is sampled; divisor below 2 outruns the data sync
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      baud_count <= '0;
      clk_gen <= 1'b1;
    end
    else if (!master || !((want_rx && state == RECV) || (want_tx && state == SEND)))
    begin
      baud_count <= '0;
      clk_gen <= 1'b1;
    end
    else if (baud_count == '0)
    begin
      baud_count <= baud_divisor[DIV_WIDTH-1:0];
      clk_gen <= !clk_gen;
    end
    else
      baud_count <= baud_count - 1'b1;
  end

  // =====================================================================
  // link state machine
  logic word_done, tx_load, tx_done;
  assign word_done = (state == RECV) && fall && (bit_count == word_bits - 4'h1);
  assign tx_done = (state == SEND) && fall && (bit_count == (nine_bit_transmit_enable ? BITS_NINE : BITS_EIGHT) - 4'h1);
  // transmit buffer moves to shifter only when shifter is free
  assign tx_load = tx_buffer_full && want_tx && !want_rx && (state == IDLE || tx_done);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= IDLE;
      bit_count <= '0;
      receive_shifter <= '0;
      transmit_shifter <= '0;
    end
    else
    begin
      case (state)
        IDLE:
        begin
          bit_count <= '0;
          if (want_rx)
            state <= RECV;
          else if (tx_load)
          begin
            state <= SEND;
            transmit_shifter <= {transmit_ninth_bit, transmit_buffer};
          end
        end
        RECV:
        begin
          if (!want_rx)
            state <= IDLE;
          else if (fall)
          begin
            // sample data on the falling clock edge, lsb first
            receive_shifter <= {dat_s2, receive_shifter[8:1]};
            bit_count <= (bit_count == word_bits - 4'h1) ? '0 : bit_count + 4'h1;
          end
        end
        SEND:
        begin
          // receive enable aborts a transmission; shifter keeps its content
          if (want_rx || !want_tx)
            state <= IDLE;
          else if (tx_done)
          begin
            bit_count <= '0;
            if (tx_load)
              transmit_shifter <= {transmit_ninth_bit, transmit_buffer};
            else
              state <= IDLE;
          end
          else if (fall)
          begin
            bit_count <= bit_count + 4'h1;
            transmit_shifter <= {1'b0, transmit_shifter[8:1]};
          end
        end
        default:
          state <= IDLE;
      endcase
    end
  end

  // data changes after the rising edge so it is stable around the falling edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      serial_data_pin_out <= 1'b1;
    else if (state == SEND && (rise || bit_count == '0))
      serial_data_pin_out <= transmit_shifter[0];
  end
  assign serial_data_pin_oe = (state == SEND);
  assign serial_clock_pin_out = clk_line;
  assign serial_clock_pin_oe = link_on && master;

  // =====================================================================
  // receive fifo with ninth bit per entry
  logic [8:0] rx_word;
  logic fifo_push, fifo_pop;
  assign rx_word = nine_bit_receive_enable ? {dat_s2, receive_shifter[8:1]} : {1'b0, dat_s2, receive_shifter[8:2]};
  // overrun blocks every push; a full fifo drops the word
  assign fifo_push = word_done && !overrun_error && fifo_count != FIFO_DEPTH;
  assign fifo_pop = rd_rx_buffer && fifo_count != 2'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fifo_rd_ptr <= 1'b0;
      fifo_wr_ptr <= 1'b0;
      fifo_count <= '0;
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
    end
    else
    begin
      if (fifo_push)
      begin
        fifo_mem[fifo_wr_ptr] <= rx_word;
        fifo_wr_ptr <= !fifo_wr_ptr;
      end
      if (fifo_pop)
        fifo_rd_ptr <= !fifo_rd_ptr;
      fifo_count <= fifo_count + {1'b0, fifo_push} - {1'b0, fifo_pop};
    end
  end
  // ready flag is the fifo's non-empty state, cleared only by reading it out
  logic receive_ready_flag;
  assign receive_ready_flag = (fifo_count != 2'h0);

  // =====================================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_port_enable <= 1'b0;
      nine_bit_receive_enable <= 1'b0;
      single_receive_enable <= 1'b0;
      continuous_receive_enable <= 1'b0;
    end
    else if (wr_rx_status)
    begin
      serial_port_enable <= pwdata[RCV_SERIAL_PORT_ENABLE];
      nine_bit_receive_enable <= pwdata[RCV_NINE];
      single_receive_enable <= pwdata[RCV_SINGLE];
      continuous_receive_enable <= pwdata[RCV_CONT];
    end
    else if (word_done && !continuous_receive_enable)
      single_receive_enable <= 1'b0;
  end

  // overrun is set by a word meeting a full fifo and cleared while continuous enable is clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overrun_error <= 1'b0;
    else if (word_done && fifo_count == FIFO_DEPTH)
      overrun_error <= 1'b1;
    else if (!continuous_receive_enable)
      overrun_error <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_source_select <= 1'b0;
      nine_bit_transmit_enable <= 1'b0;
      transmit_enable <= 1'b0;
      sync_mode <= 1'b0;
      high_baud_select <= 1'b0;
      transmit_ninth_bit <= 1'b0;
      irq_enables <= RST_BYTE;
      baud_divisor <= RST_BYTE;
    end
    else if (wr_access)
    begin
      if (hit(paddr, IDX_TX_STATUS))
      begin
        clock_source_select <= pwdata[TXS_CLKSRC];
        nine_bit_transmit_enable <= pwdata[TXS_NINE];
        transmit_enable <= pwdata[TXS_ENABLE];
        sync_mode <= pwdata[TXS_SYNC];
        high_baud_select <= pwdata[TXS_HIGHBAUD];
        transmit_ninth_bit <= pwdata[TXS_NINTH];
      end
      else if (hit(paddr, IDX_IRQ_ENABLES))
        irq_enables <= pwdata[7:0];
      else if (hit(paddr, IDX_BAUD))
        baud_divisor <= pwdata[7:0];
    end
  end

  // transmit buffer: a load into the shifter empties it; a new write fills it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      transmit_buffer <= RST_BYTE;
      tx_buffer_full <= 1'b0;
    end
    else if (wr_tx_buffer)
    begin
      transmit_buffer <= pwdata[7:0];
      tx_buffer_full <= 1'b1;
    end
    else if (tx_load || !transmit_enable)
      tx_buffer_full <= 1'b0;
  end

  // =====================================================================
  // interrupt request and wake
  logic transmit_empty_flag;
  assign transmit_empty_flag = !tx_buffer_full;
  always_comb
  begin
    irq_request = (receive_ready_flag && irq_enables[IRQ_RX]) ||
                  (transmit_empty_flag && irq_enables[IRQ_TX]);
    wake_request = sleeping && irq_request;
  end

  // =====================================================================
  // read data, registered in the setup phase
  logic [8:0] fifo_head;
  assign fifo_head = fifo_mem[fifo_rd_ptr];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      if (hit(paddr, IDX_IRQ_FLAGS))
        prdata <= {26'h0, receive_ready_flag, transmit_empty_flag, 4'h0};
      else if (hit(paddr, IDX_RX_STATUS))
        // ninth bit shown is that of the entry at the head of the fifo
        prdata <= {24'h0, serial_port_enable, nine_bit_receive_enable, single_receive_enable,
                   continuous_receive_enable, 2'b00, overrun_error, fifo_head[8]};
      else if (hit(paddr, IDX_RX_BUFFER))
        prdata <= {24'h0, fifo_head[7:0]};
      else if (hit(paddr, IDX_IRQ_ENABLES))
        prdata <= {24'h0, irq_enables};
      else if (hit(paddr, IDX_TX_STATUS))
        prdata <= {24'h0, clock_source_select, nine_bit_transmit_enable, transmit_enable, sync_mode,
                   1'b0, high_baud_select, state != SEND, transmit_ninth_bit};
      else if (hit(paddr, IDX_BAUD))
        prdata <= {24'h0, baud_divisor};
      else
        prdata <= '0;
    end
  end
endmodule

// ===== sync_usart_rx_asserts.sv
// checker: port-level properties of the synchronous serial port
module sync_usart_rx_asserts
  import sync_usart_pkg::*;
#(
  parameter int DIV_WIDTH = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleeping,
  input wire logic irq_request,
  input wire logic wake_request,
  input wire logic serial_clock_pin_in,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe,
  input wire logic serial_data_pin_in,
  input wire logic serial_data_pin_out,
  input wire logic serial_data_pin_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic acc;
  logic mapped;
  logic master;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [7:0] en_q;
  logic [3:0] quiet;
  // ==========================================================
  // decode: misaligned or outside the map counts as unmapped
  assign acc = psel & penable & pready;
  assign mapped = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 && paddr[9:2] inside
    {IDX_IRQ_FLAGS, IDX_RX_STATUS, IDX_TX_BUFFER, IDX_RX_BUFFER, IDX_IRQ_ENABLES, IDX_TX_STATUS, IDX_BAUD};
  assign master = tx_q[TXS_CLKSRC] & tx_q[TXS_SYNC] & rx_q[RCV_SERIAL_PORT_ENABLE];
  // software view of control bits; hardware clearing of single enable is not mirrored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      en_q <= 8'h00;
    end
    else if (acc && pwrite && mapped)
    begin
      if (paddr[9:2] == IDX_RX_STATUS)
        rx_q <= pwdata[7:0];
      if (paddr[9:2] == IDX_TX_STATUS)
        tx_q <= pwdata[7:0];
      if (paddr[9:2] == IDX_IRQ_ENABLES)
        en_q <= pwdata[7:0];
    end
  end
  // cycles with single, continuous and transmit enables clear; saturates so it never wraps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      quiet <= 4'h0;
    else if (rx_q[RCV_SINGLE] | rx_q[RCV_CONT] | tx_q[TXS_ENABLE])
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (psel && penable |-> pready) else $error("pready low");
  a_refuse_flag: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
  a_refuse_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0) else $error("unmapped data");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  a_irq_masked: assert property (en_q[IRQ_RX] == 1'b0 && en_q[IRQ_TX] == 1'b0 |-> !irq_request) else $error("irq");
  a_wake_sleep: assert property (wake_request == (sleeping && irq_request)) else $error("wake");
  a_rx_release: assert property (rx_q[RCV_CONT] [*2] |-> !serial_data_pin_oe) else $error("data pin");
  a_clock_role: assert property (master == $past(master) |-> serial_clock_pin_oe == master) else $error("role");
  a_clock_idle: assert property (quiet == 4'hF && serial_clock_pin_oe |-> serial_clock_pin_out) else $error("clk");
  c_overrun: cover property (acc && !pwrite && paddr[9:2] == IDX_RX_STATUS && prdata[RCV_OVERRUN]);
  c_wake: cover property (wake_request);
  c_master_clock: cover property (serial_clock_pin_oe && !serial_clock_pin_out);
endmodule

bind sync_usart_rx sync_usart_rx_asserts #(.DIV_WIDTH(DIV_WIDTH)) chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sleeping(sleeping), .irq_request(irq_request),
  .wake_request(wake_request), .serial_clock_pin_in(serial_clock_pin_in),
  .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
  .serial_data_pin_in(serial_data_pin_in), .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe(serial_data_pin_oe));

// ===== sync_link_peer.sv
// partner model: external synchronous device on the shift clock and data lines
module sync_link_peer
(
  input wire logic line_clk,
  input wire logic line_data,
  output logic peer_clk,
  output logic peer_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] word;
  logic [7:0] got;
  int nbits;
  int idx;
  // idle: clock high, nothing pending
  initial
  begin
    peer_clk = 1'b1;
    peer_data = 1'b1;
    word = 9'h000;
    nbits = 0;
    idx = 0;
  end
  // next bit after each rising edge, settled well before the sampling fall; past the word it toggles
  always @(posedge line_clk)
  begin
    if (idx < nbits)
    begin
      peer_data = word[idx];
      idx = idx + 1;
    end
    else
      peer_data = ~peer_data;
  end
  // capture what the line carries at each falling edge, lsb first
  always @(negedge line_clk)
    got = {line_data, got[7:1]};
  // arm a word, lsb on the line at once
  task automatic arm(input logic [8:0] w, input int n);
    word = w;
    nbits = n;
    idx = 1;
    peer_data = w[0];
  endtask
  // slave shift clock, 160 ns period, off the core clock phase, high between frames
  task automatic pulse(input int n);
    #3;
    repeat (n)
    begin
      #80 peer_clk = 1'b0;
      #80 peer_clk = 1'b1;
    end
  endtask
endmodule

// ===== sync_usart_rx_and_slave_tb.sv
// testbench: register-level tests of the synchronous serial port
module sync_usart_rx_and_slave_tb
  import sync_usart_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleeping, irq_request, wake_request;
  logic clk_out, clk_oe, data_out, data_oe, peer_clk, peer_data, line_clk, line_data, err;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  int n_fail;
  int checks_done;
  // pins resolve from the port's enables; the peer drives whenever they are low
  assign line_clk = clk_oe ? clk_out : peer_clk;
  assign line_data = data_oe ? data_out : peer_data;
  sync_usart_rx #(.DIV_WIDTH(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleeping(sleeping), .irq_request(irq_request), .wake_request(wake_request),
    .serial_clock_pin_in(line_clk), .serial_clock_pin_out(clk_out), .serial_clock_pin_oe(clk_oe),
    .serial_data_pin_in(line_data), .serial_data_pin_out(data_out), .serial_data_pin_oe(data_oe));
  sync_link_peer peer (.line_clk(line_clk), .line_data(line_data), .peer_clk(peer_clk), .peer_data(peer_data));
  // ==========================================================
  // clock and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #400000;
    n_fail++;
    finish_test();
  end
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ==========================================================
  // apb transfer: request held until pready seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] ix, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, ix, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reg_is(input string what, input logic [7:0] ix, input logic [7:0] mask, input logic [7:0] exp);
    apb(1'b0, ix, 8'h00);
    check(what, rd & {24'h0, mask}, {24'h0, exp & mask});
  endtask
  // bounded poll; the compare after it reports a miss
  task automatic poll(input logic [7:0] ix, input int b);
    rd = 32'h0;
    for (int i = 0; i < 60 && rd[b] !== 1'b1; i++)
      apb(1'b0, ix, 8'h00);
  endtask
  // slave word of nine bits, then the two-flop input sync settles
  task automatic send(input logic [8:0] w);
    peer.arm(w, 9);
    peer.pulse(9);
    repeat (8) @(posedge pclk);
  endtask
  // ==========================================================
  // tests
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sleeping = 1'b0;
    n_fail = 0;
    checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values; tx empty flag masked out of the flags read, though this port resets it set
    reg_is("tx status", IDX_TX_STATUS, 8'hFF, 8'h02);
    reg_is("flags", IDX_IRQ_FLAGS, 8'hEF, 8'h00);
    reg_is("enables", IDX_IRQ_ENABLES, 8'hFF, 8'h00);
    reg_is("baud", IDX_BAUD, 8'hFF, 8'h00);
    reg_is("rx buffer", IDX_RX_BUFFER, 8'hFF, 8'h00);
    reg_is("rx status", IDX_RX_STATUS, 8'hFE, 8'h00);
    apb(1'b0, 8'h01, 8'h00);
    check("unmapped err", {31'h0, err}, 32'h1);
    $display("test reset done");
    // master single receive, set up with both enables clear first
    // half period of five cycles leaves room for the two-flop data sync
    apb(1'b1, IDX_BAUD, 8'h04);
    apb(1'b1, IDX_TX_STATUS, 8'h90);
    apb(1'b1, IDX_RX_STATUS, 8'h80);
    reg_is("baud", IDX_BAUD, 8'hFF, 8'h04);
    peer.arm(9'h0C3, 8);
    apb(1'b1, IDX_RX_STATUS, 8'hA0);
    poll(IDX_IRQ_FLAGS, IRQ_RX);
    check("masked irq", {31'h0, irq_request}, 32'h0);
    reg_is("rx status", IDX_RX_STATUS, 8'hFE, 8'h80);
    reg_is("rx buffer", IDX_RX_BUFFER, 8'hFF, 8'hC3);
    apb(1'b1, IDX_IRQ_FLAGS, 8'h20);
    reg_is("ready flag", IDX_IRQ_FLAGS, 8'h20, 8'h00);
    $display("test master done");
    // slave: single enable ignored, then continuous in sleep up to overrun
    apb(1'b1, IDX_TX_STATUS, 8'h10);
    apb(1'b1, IDX_RX_STATUS, 8'hE0);
    send(9'h15A);
    reg_is("single ignored", IDX_IRQ_FLAGS, 8'h20, 8'h00);
    apb(1'b1, IDX_IRQ_ENABLES, 8'h20);
    apb(1'b1, IDX_RX_STATUS, 8'hD0);
    sleeping <= 1'b1;
    send(9'h1A5);
    check("wake", {31'h0, wake_request}, 32'h1);
    send(9'h03C);
    send(9'h1FF);
    reg_is("overrun", IDX_RX_STATUS, 8'hFF, 8'hD3);
    reg_is("first", IDX_RX_BUFFER, 8'hFF, 8'hA5);
    reg_is("ninth", IDX_RX_STATUS, 8'hFF, 8'hD2);
    reg_is("second", IDX_RX_BUFFER, 8'hFF, 8'h3C);
    reg_is("drained", IDX_IRQ_FLAGS, 8'h20, 8'h00);
    send(9'h055);
    reg_is("blocked", IDX_IRQ_FLAGS, 8'h20, 8'h00);
    apb(1'b1, IDX_RX_STATUS, 8'hC0);
    reg_is("overrun clear", IDX_RX_STATUS, 8'hFE, 8'hC0);
    sleeping <= 1'b0;
    $display("test slave done");
    // slave transmit: two words queued, second waits in the buffer until the first is out
    apb(1'b1, IDX_IRQ_ENABLES, 8'h10);
    apb(1'b1, IDX_TX_STATUS, 8'h30);
    apb(1'b1, IDX_TX_BUFFER, 8'h96);
    apb(1'b1, IDX_TX_BUFFER, 8'h4B);
    sleeping <= 1'b1;
    reg_is("tx held", IDX_IRQ_FLAGS, 8'h10, 8'h00);
    check("no wake", {31'h0, wake_request}, 32'h0);
    peer.pulse(8);
    repeat (8) @(posedge pclk);
    check("first out", {24'h0, peer.got}, 32'h96);
    check("tx wake", {31'h0, wake_request}, 32'h1);
    peer.pulse(8);
    repeat (8) @(posedge pclk);
    check("second out", {24'h0, peer.got}, 32'h4B);
    sleeping <= 1'b0;
    $display("test slave transmit done");
    finish_test();
  end
endmodule
